// File: fcu_pkg.sv
// Constants, types and field layout shared by the float compare unit.
// Function
// [RQ1] The flags operation computes the IEEE exceptions of first >= second and writes them as a vector.
// [RQ2] The flags vector uses the status layout: bits 0..6 are divide-by-zero up to output-flushed, zeros above.
// [RQ3] The flags operation never changes the status word flags; it only writes its destination.
// [RQ4] A denormal operand of the flags operation compares as zero and sets input-flushed in the vector.
// [RQ5] A guarded flags operation writes its destination only when the guard's low bit is 1.
// [RQ6] The greater compare writes 1 when first exceeds second and 0 in every other case.
// [RQ7] The greater compare flushes denormal operands to zero and sets input-flushed in the status word.
// [RQ8] Exceptions raised by the greater compare set the matching status word flags.
// [RQ9] Status word flags are sticky and are cleared only by an explicit status word write.
// [RQ10] The status flag update of the greater compare lands in the same cycle as its writeback.
// [RQ11] Simultaneous status updates are ORed together and with the flag's existing value.
// [RQ12] A greater compare with a false guard changes neither destination nor status flags.
// [RQ13] A greater compare with a quiet NaN operand returns 0 and raises bad operation.
// [RQ14] Both operations deliver their result one cycle after issue.
package fcu_pkg;

    // ----------
    // Operation codes and widths
    // ----------
    localparam int unsigned OPC_W        = 8;
    localparam logic [7:0]  OPC_GTR      = 8'h90;   // Decimal 144.
    localparam logic [7:0]  OPC_GEQFLAGS = 8'h93;   // Decimal 147.
    localparam int unsigned DATA_W       = 32;
    localparam int unsigned DEST_W       = 7;
    localparam int unsigned EXC_W        = 7;

    // ----------
    // Single-precision field layout
    // ----------
    localparam int unsigned SIGN_BIT  = 31;
    localparam int unsigned EXP_HI    = 30;
    localparam int unsigned EXP_LO    = 23;
    localparam int unsigned MANT_HI   = 22;
    localparam logic [7:0]  EXP_ZERO  = 8'h00;
    localparam logic [7:0]  EXP_ONES  = 8'hFF;
    localparam logic [22:0] MANT_ZERO = 23'h00_0000;

    // ----------
    // Exception flag positions
    // ----------
    localparam int unsigned DIVIDE_BY_ZERO_FLAG      = 0;
    localparam int unsigned INEXACT_FLAG             = 1;
    localparam int unsigned UNDERFLOW_FLAG           = 2;
    localparam int unsigned OVERFLOW_FLAG            = 3;
    localparam int unsigned BAD_OPERATION_FLAG       = 4;
    localparam int unsigned INPUT_FLUSHED_ZERO_FLAG  = 5;
    localparam int unsigned OUTPUT_FLUSHED_ZERO_FLAG = 6;
    localparam logic [6:0]  EXC_NONE                 = 7'h00;

    // ----------
    // Register map (byte addresses) and reset values
    // ----------
    localparam int unsigned AXI_AW        = 4;
    localparam logic [3:0]  REG_STATUS    = 4'h0;
    localparam logic [3:0]  REG_MASK      = 4'h4;
    localparam logic [3:0]  REG_CONTROL   = 4'h8;
    localparam logic [3:0]  REG_COUNT     = 4'hC;
    localparam logic [6:0]  MASK_RESET    = 7'h00;
    localparam int unsigned CTRL_ENABLE   = 0;
    localparam logic        ENABLE_RESET  = 1'b1;
    localparam logic [1:0]  RESP_OKAY     = 2'b00;
    localparam logic [1:0]  RESP_SLVERR   = 2'b10;
    localparam logic [31:0] WORD_ZERO     = 32'h0000_0000;
    localparam logic [31:0] WORD_ONE      = 32'h0000_0001;

    // ----------
    // Types
    // ----------
    typedef enum logic [1:0] {OP_NONE, OP_GTR, OP_GEQFLAGS} opKind_t;

    typedef struct packed {
        logic              valid;
        logic [OPC_W-1:0]  opcode;
        logic [31:0]       firstSource;
        logic [31:0]       secondSource;
        logic              guardPresent;
        logic [31:0]       guard;
        logic [DEST_W-1:0] dest;
    } issueReq_t;

    typedef struct packed {
        logic              valid;
        logic [DEST_W-1:0] dest;
        logic [31:0]       data;
    } writeback_t;

endpackage : fcu_pkg

// File: fcu_reg_file_model.sv
// Register file model that takes the unit's writebacks from the far side.
module fcu_reg_file_model
    import fcu_pkg::*;
(
    input wire logic                clk,
    input wire fcu_pkg::writeback_t result
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------
    // Storage
    // ----------
    logic [31:0] regFile [128];
    // A marker start value makes an unwritten destination visible.
    initial begin
        for (int i = 0; i < 128; i++) begin
            regFile[i] = 32'h5A5A_5A5A;
        end
    end
    // Only a writeback pulse changes an entry; all others keep their value.
    always @(posedge clk) begin
        if (result.valid) begin
            regFile[result.dest] <= result.data;
        end
    end
endmodule : fcu_reg_file_model

// File: float_compare_unit.sv
// Float compare unit: greater compare, greater-or-equal flags, status word, AXI4-Lite.
module float_compare_unit (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 ce,
    input  wire fcu_pkg::issueReq_t   issue,
    input  wire logic [6:0]           otherExcSet,
    output fcu_pkg::writeback_t       writeback_ff,
    output logic                      irq_ff,
    input  wire logic [3:0]           s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [3:0]           s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready
);
    import fcu_pkg::*;

    // ----------
    // Declarations
    // ----------
    logic [6:0]  statusWord_ff;
    logic [6:0]  nxt_statusWord;
    logic [6:0]  irqMask_ff;
    logic        unitEnable_ff;
    logic [31:0] opCount_ff;
    logic [3:0]  awAddr_ff;
    logic        awHeld_ff;
    logic [31:0] wData_ff;
    logic [3:0]  wStrb_ff;
    logic        wHeld_ff;
    logic        writeFire;
    logic        statusWrite;
    logic [31:0] nxt_rdata;
    logic [1:0]  nxt_rresp;
    logic [1:0]  nxt_bresp;

    logic [31:0] firstFlushed;
    logic [31:0] secondFlushed;
    logic        firstDenorm;
    logic        secondDenorm;
    logic        firstNan;
    logic        secondNan;
    logic        firstZero;
    logic        secondZero;
    opKind_t     opKind;
    logic        guardPass;
    logic        execute;
    logic        anyNan;
    logic        greater;
    logic        equal;
    logic [6:0]  cmpExc;
    logic [6:0]  gtrSet;

    // ----------
    // Operand classification
    // ----------
    fp_operand_classify firstClass (
        .operand  (issue.firstSource),
        .flushed  (firstFlushed),
        .isDenorm (firstDenorm),
        .isNan    (firstNan),
        .isZero   (firstZero)
    );

    fp_operand_classify secondClass (
        .operand  (issue.secondSource),
        .flushed  (secondFlushed),
        .isDenorm (secondDenorm),
        .isNan    (secondNan),
        .isZero   (secondZero)
    );

    // ----------
    // Decode and guard
    // ----------

    // Opcodes that are not ours are ignored, so a shared issue bus is safe.
    always_comb begin
        if (!issue.valid || !unitEnable_ff) begin
            opKind = OP_NONE;
        end else if (issue.opcode == OPC_GTR) begin
            opKind = OP_GTR;
        end else if (issue.opcode == OPC_GEQFLAGS) begin
            opKind = OP_GEQFLAGS;
        end else begin
            opKind = OP_NONE;
        end
    end

    // An absent guard counts as true; a present one is judged by its low bit.
    assign guardPass = !issue.guardPresent || issue.guard[0];       // [RQ5] [RQ12]
    assign execute   = (opKind != OP_NONE) && guardPass;

    // ----------
    // Compare datapath
    // ----------

    // Ordered compare on flushed values; both zeros are equal whatever their sign.
    always_comb begin
        anyNan  = firstNan || secondNan;
        equal   = 1'b0;
        greater = 1'b0;
        if (anyNan) begin
            equal   = 1'b0;                                         // [RQ13]
            greater = 1'b0;                                         // [RQ13]
        end else if (firstZero && secondZero) begin
            equal = 1'b1;
        end else if (firstFlushed == secondFlushed) begin
            equal = 1'b1;
        end else if (firstFlushed[SIGN_BIT] != secondFlushed[SIGN_BIT]) begin
            greater = !firstFlushed[SIGN_BIT];                      // [RQ6]
        end else if (!firstFlushed[SIGN_BIT]) begin
            greater = firstFlushed[EXP_HI:0] > secondFlushed[EXP_HI:0];
        end else begin
            greater = firstFlushed[EXP_HI:0] < secondFlushed[EXP_HI:0];
        end
    end

    // Both compares raise the same exceptions: any NaN is invalid, and
    // a flushed input is reported; nothing else can arise from a compare.
    always_comb begin
        cmpExc = EXC_NONE;
        cmpExc[BAD_OPERATION_FLAG]      = anyNan;                   // [RQ1] [RQ13]
        cmpExc[INPUT_FLUSHED_ZERO_FLAG] = firstDenorm || secondDenorm; // [RQ4] [RQ7]
    end

    // Of the two operations, only an executing greater compare feeds the status word.
    assign gtrSet = (execute && opKind == OP_GTR) ? cmpExc : EXC_NONE; // [RQ3] [RQ8] [RQ12]

    // ----------
    // Writeback register
    // ----------

    // One cycle from issue to writeback; the valid strobe is one pulse.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            writeback_ff <= '0;
        end else if (ce) begin
            writeback_ff.valid <= execute;                          // [RQ14] [RQ5] [RQ12]
            if (execute) begin
                writeback_ff.dest <= issue.dest;
                if (opKind == OP_GTR) begin
                    writeback_ff.data <= greater ? WORD_ONE : WORD_ZERO; // [RQ6]
                end else begin
                    writeback_ff.data <= {25'h000_0000, cmpExc};    // [RQ1] [RQ2]
                end
            end
        end
    end

    // ----------
    // Status word
    // ----------

    // Sticky flags: a write of one clears, but a same-cycle set wins.
    always_comb begin
        nxt_statusWord = statusWord_ff;
        if (statusWrite) begin
            nxt_statusWord = statusWord_ff & ~wData_ff[EXC_W-1:0];  // [RQ9]
        end
        nxt_statusWord = nxt_statusWord | gtrSet | otherExcSet;     // [RQ11] [RQ9]
    end

    // Updated on the same edge as the writeback register above.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            statusWord_ff <= EXC_NONE;
        end else if (ce) begin
            statusWord_ff <= nxt_statusWord;                        // [RQ10]
        end
    end

    // Interrupt level follows the masked flags one cycle later.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_ff <= 1'b0;
        end else if (ce) begin
            irq_ff <= |(statusWord_ff & irqMask_ff);
        end
    end

    // Count of compares that actually wrote back, for software visibility.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            opCount_ff <= WORD_ZERO;
        end else if (ce && execute) begin
            opCount_ff <= opCount_ff + WORD_ONE;
        end
    end

    // ----------
    // AXI4-Lite write channel
    // ----------
    assign writeFire   = awHeld_ff && wHeld_ff && !s_axi_bvalid;
    assign statusWrite = writeFire && (awAddr_ff == REG_STATUS) && wStrb_ff[0];

    // Address and data are held independently; ready drops until the
    // response is taken, so one write at a time is in flight.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            awAddr_ff     <= REG_STATUS;
            awHeld_ff     <= 1'b0;
            s_axi_awready <= 1'b1;
            wData_ff      <= WORD_ZERO;
            wStrb_ff      <= 4'h0;
            wHeld_ff      <= 1'b0;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                awAddr_ff     <= s_axi_awaddr;
                awHeld_ff     <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wData_ff     <= s_axi_wdata;
                wStrb_ff     <= s_axi_wstrb;
                wHeld_ff     <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (writeFire) begin
                awHeld_ff    <= 1'b0;
                wHeld_ff     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= nxt_bresp;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Write decode; only byte lane 0 carries register bits.
    always_comb begin
        if (awAddr_ff == REG_STATUS || awAddr_ff == REG_MASK) begin
            nxt_bresp = RESP_OKAY;
        end else if (awAddr_ff == REG_CONTROL || awAddr_ff == REG_COUNT) begin
            nxt_bresp = RESP_OKAY;
        end else begin
            nxt_bresp = RESP_SLVERR;
        end
    end

    // Software-written mask and enable.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irqMask_ff    <= MASK_RESET;
            unitEnable_ff <= ENABLE_RESET;
        end else if (ce && writeFire && wStrb_ff[0]) begin
            if (awAddr_ff == REG_MASK) begin
                irqMask_ff <= wData_ff[EXC_W-1:0];
            end else if (awAddr_ff == REG_CONTROL) begin
                unitEnable_ff <= wData_ff[CTRL_ENABLE];
            end
        end
    end

    // ----------
    // AXI4-Lite read channel
    // ----------

    // Read decode; unmapped addresses answer zero with an error.
    always_comb begin
        nxt_rresp = RESP_OKAY;
        if (s_axi_araddr == REG_STATUS) begin
            nxt_rdata = {25'h000_0000, statusWord_ff};
        end else if (s_axi_araddr == REG_MASK) begin
            nxt_rdata = {25'h000_0000, irqMask_ff};
        end else if (s_axi_araddr == REG_CONTROL) begin
            nxt_rdata = {31'h0000_0000, unitEnable_ff};
        end else if (s_axi_araddr == REG_COUNT) begin
            nxt_rdata = opCount_ff;
        end else begin
            nxt_rdata = WORD_ZERO;
            nxt_rresp = RESP_SLVERR;
        end
    end

    // Data are captured at the address handshake and held until taken.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= WORD_ZERO;
            s_axi_rresp   <= RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= nxt_rdata;
                s_axi_rresp   <= nxt_rresp;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule : float_compare_unit

// File: float_compare_unit_checker.sv
// Concurrent checks on the issue and writeback ports of the float compare unit.
module float_compare_unit_checker
    import fcu_pkg::*;
(
    input wire logic                clk,
    input wire logic                rst_n,
    input wire logic                ce,
    input wire fcu_pkg::issueReq_t  issue,
    input wire fcu_pkg::writeback_t writeback_ff
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------
    // Issue decode
    // ----------
    logic isGtr, isGeq, take, anyNan, anyDen, same;
    // Only the low guard bit decides; the rest of the guard word is don't-care.
    assign isGtr  = issue.opcode == OPC_GTR;
    assign isGeq  = issue.opcode == OPC_GEQFLAGS;
    assign take   = ce && issue.valid && (isGtr || isGeq) && (!issue.guardPresent || issue.guard[0]);
    assign anyNan = (&issue.firstSource[30:23] && |issue.firstSource[22:0])
                 || (&issue.secondSource[30:23] && |issue.secondSource[22:0]);
    assign anyDen = (~|issue.firstSource[30:23] && |issue.firstSource[22:0])
                 || (~|issue.secondSource[30:23] && |issue.secondSource[22:0]);
    assign same   = issue.firstSource == issue.secondSource;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ----------
    // Issue to writeback
    // ----------
    sequence sExec; take ##1 writeback_ff.valid; endsequence
    sequence sGtr;  (take && isGtr) ##1 writeback_ff.valid; endsequence
    sequence sGeq;  (take && isGeq) ##1 writeback_ff.valid; endsequence

    a_result_cause: assert property (
        writeback_ff.valid |-> $past(take)) else $error("Writeback without an executed issue.");
    a_dest_echo: assert property (
        sExec |-> writeback_ff.dest == $past(issue.dest)) else $error("Writeback dest wrong.");
    a_gtr_bool: assert property (
        sGtr |-> writeback_ff.data[31:1] == 31'h0000_0000) else $error("Greater result not 0/1.");
    a_gtr_nan: assert property (
        (take && isGtr && anyNan) ##1 writeback_ff.valid |-> writeback_ff.data == WORD_ZERO)
        else $error("Greater with NaN not 0.");
    a_gtr_equal: assert property (
        (take && isGtr && same) ##1 writeback_ff.valid |-> writeback_ff.data == WORD_ZERO)
        else $error("Greater of equal operands not 0.");
    a_geq_layout: assert property (
        sGeq |-> writeback_ff.data[31:6] == 26'h000_0000 && writeback_ff.data[3:0] == 4'h0)
        else $error("Flags vector has stray bits.");
    a_geq_invalid: assert property (
        sGeq |-> writeback_ff.data[4] == $past(anyNan)) else $error("Flags invalid bit wrong.");
    a_geq_flushed: assert property (
        sGeq |-> writeback_ff.data[5] == $past(anyDen)) else $error("Flags flushed bit wrong.");
    a_data_hold: assert property (
        !writeback_ff.valid |-> $stable(writeback_ff.data)) else $error("Result changed idle.");
endmodule : float_compare_unit_checker

bind float_compare_unit float_compare_unit_checker u_checker (
    .clk(clk), .rst_n(rst_n), .ce(ce), .issue(issue), .writeback_ff(writeback_ff));

// File: fp_operand_classify.sv
// Classifies one single-precision operand and flushes denormals to zero.
module fp_operand_classify (
    input  wire logic [31:0] operand,
    output logic      [31:0] flushed,
    output logic             isDenorm,
    output logic             isNan,
    output logic             isZero
);
    import fcu_pkg::*;

    logic [7:0]  expField;
    logic [22:0] mantField;

    // Field split and class decode; a flushed denormal keeps its sign bit.
    always_comb begin
        expField  = operand[EXP_HI:EXP_LO];
        mantField = operand[MANT_HI:0];
        isDenorm  = (expField == EXP_ZERO) && (mantField != MANT_ZERO);
        isNan     = (expField == EXP_ONES) && (mantField != MANT_ZERO);
        isZero    = (expField == EXP_ZERO);
        flushed   = isDenorm ? {operand[SIGN_BIT], 31'h0000_0000} : operand;
    end

endmodule : fp_operand_classify

// File: tb_float_compare_unit.sv
// Self-checking bench for the float compare unit.
module tb_float_compare_unit
    import fcu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ----------
    // Signals and operand table
    // ----------
    localparam logic [31:0] F1 = 32'h3F80_0000, F3 = 32'h4040_0000, QNAN = 32'h7FC0_0000;
    localparam logic [31:0] DEN = 32'h0040_0000, MARK = 32'h5A5A_5A5A;
    logic [31:0] opA [8] = '{F3, F3, F1, F3, F3, 32'h7F80_0000, F1, 32'h7F80_0000};
    logic [31:0] opB [8] = '{32'h0000_0000, F3, F3, F1, QNAN, 32'hFF80_0000, DEN, 32'h7F80_0000};
    logic [31:0] gtrExp [8] = '{1, 0, 0, 1, 0, 1, 1, 0};
    logic [31:0] geqExp [8] = '{0, 0, 0, 0, 32'h0000_0010, 0, 32'h0000_0020, 0};
    logic        clk, rst_n, ce, irq;
    issueReq_t   iss;
    writeback_t  wb;
    logic [6:0]  oth;
    logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int          bad_count, checks, execs;
    logic        unitOn = ENABLE_RESET;

    float_compare_unit u_dut (.clk, .rst_n, .ce, .issue(iss), .otherExcSet(oth),
        .writeback_ff(wb), .irq_ff(irq), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    fcu_reg_file_model regs (.clk(clk), .result(wb));

    // ----------
    // Shared tasks
    // ----------
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic results();
        $display("Checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results

    // A wait that runs out counts as a mismatch and ends the run.
    task automatic expire(input int n);
        if (n > 40) begin
            bad_count++;
            results();
        end
    endtask : expire

    // Address and data go out together; each is released once its own ready is seen.
    task automatic axw(input logic [3:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            expire(n);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk("bresp", 32'(a[1:0] == 2'b00 ? RESP_OKAY : RESP_SLVERR), 32'(s_axi_bresp));
    endtask : axw

    task automatic axr(input logic [3:0] a, output logic [31:0] d);
        int n = 0;
        @(posedge clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            expire(n);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
        chk("rresp", 32'(a[1:0] == 2'b00 ? RESP_OKAY : RESP_SLVERR), 32'(s_axi_rresp));
    endtask : axr

    // One issue cycle; other units' exception sets ride in the same cycle.
    task automatic op(input logic [7:0] opc, input logic [31:0] a, input logic [31:0] b,
                      input logic gp, input logic g, input logic [6:0] d, input logic [6:0] x);
        @(posedge clk);
        iss <= '{1'b1, opc, a, b, gp, {31'h0000_0000, g}, d};
        oth <= x;
        @(posedge clk);
        iss.valid <= 1'b0;
        oth <= 7'h00;
        @(posedge clk);
        #1;
        if ((!gp || g) && ce && unitOn && (opc == OPC_GTR || opc == OPC_GEQFLAGS)) execs++;
    endtask : op

    // ----------
    // Scenarios
    // ----------
    task automatic tReset();
        logic [31:0] v;
        chk("irq", WORD_ZERO, {31'h0000_0000, irq});
        axr(REG_STATUS, v);
        chk("status", WORD_ZERO, v);
        axr(REG_MASK, v);
        chk("mask", WORD_ZERO, v);
        axr(REG_CONTROL, v);
        chk("control", WORD_ONE, v);
        axr(REG_COUNT, v);
        chk("count", WORD_ZERO, v);
        $display("tReset done");
    endtask : tReset

    task automatic tGtr();
        logic [31:0] v;
        axw(REG_STATUS, 32'h0000_007F);
        for (int i = 0; i < 8; i++) begin
            op(OPC_GTR, opA[i], opB[i], i == 2, 1'b1, 7'(i), 7'h00);
            chk("greater result", gtrExp[i], regs.regFile[i]);
        end
        axr(REG_STATUS, v);
        chk("greater status", 32'h0000_0030, v);
        $display("tGtr done");
    endtask : tGtr

    task automatic tGeq();
        logic [31:0] v;
        axw(REG_STATUS, 32'h0000_007F);
        for (int i = 0; i < 8; i++) begin
            op(OPC_GEQFLAGS, opA[i], opB[i], i == 2, 1'b1, 7'(16 + i), 7'h00);
            chk("flags result", geqExp[i], regs.regFile[16 + i]);
        end
        axr(REG_STATUS, v);
        chk("flags status", WORD_ZERO, v);
        $display("tGeq done");
    endtask : tGeq

    task automatic tGuard();
        logic [31:0] v;
        op(OPC_GTR, QNAN, F1, 1'b1, 1'b0, 7'h28, 7'h00);
        chk("greater guarded", MARK, regs.regFile[40]);
        op(OPC_GEQFLAGS, F1, DEN, 1'b1, 1'b0, 7'h29, 7'h00);
        chk("flags guarded", MARK, regs.regFile[41]);
        axr(REG_STATUS, v);
        chk("guarded status", WORD_ZERO, v);
        $display("tGuard done");
    endtask : tGuard

    task automatic tRefuse();
        logic [31:0] v;
        axw(4'h2, WORD_ONE);
        axr(4'h2, v);
        chk("unmapped read", WORD_ZERO, v);
        op(8'h91, F3, QNAN, 1'b0, 1'b0, 7'h2A, 7'h00);
        chk("foreign opcode", MARK, regs.regFile[42]);
        axw(REG_CONTROL, WORD_ZERO);
        unitOn = 1'b0;
        op(OPC_GTR, F3, QNAN, 1'b0, 1'b0, 7'h2B, 7'h00);
        chk("disabled unit", MARK, regs.regFile[43]);
        axw(REG_CONTROL, WORD_ONE);
        unitOn = 1'b1;
        ce <= 1'b0;
        op(OPC_GTR, F3, QNAN, 1'b0, 1'b0, 7'h2C, 7'h00);
        ce <= 1'b1;
        chk("frozen unit", MARK, regs.regFile[44]);
        axr(REG_STATUS, v);
        chk("refused status", WORD_ZERO, v);
        $display("tRefuse done");
    endtask : tRefuse

    task automatic tOrIrq();
        logic [31:0] v;
        axw(REG_MASK, 32'h0000_007F);
        op(OPC_GEQFLAGS, F3, F1, 1'b0, 1'b0, 7'h30, 7'h01);
        op(OPC_GTR, F3, QNAN, 1'b0, 1'b0, 7'h31, 7'h08);
        axr(REG_STATUS, v);
        chk("merged status", 32'h0000_0019, v);
        chk("irq raised", WORD_ONE, {31'h0000_0000, irq});
        axw(REG_MASK, WORD_ZERO);
        repeat (2) @(posedge clk);
        #1;
        chk("irq masked", WORD_ZERO, {31'h0000_0000, irq});
        axw(REG_MASK, 32'h0000_007F);
        axw(REG_STATUS, 32'h0000_0019);
        axr(REG_STATUS, v);
        chk("cleared status", WORD_ZERO, v);
        repeat (2) @(posedge clk);
        #1;
        chk("irq cleared", WORD_ZERO, {31'h0000_0000, irq});
        axw(REG_COUNT, WORD_ZERO);
        axr(REG_COUNT, v);
        chk("op count", 32'(execs), v);
        $display("tOrIrq done");
    endtask : tOrIrq

    // ----------
    // Clock and main sequence
    // ----------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, iss, oth} = '0;
        ce = 1'b1;
        s_axi_wstrb = 4'hF;
        bad_count = 0;
        checks = 0;
        execs = 0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        tReset();
        tGtr();
        tGeq();
        tGuard();
        tRefuse();
        tOrIrq();
        results();
    end
endmodule : tb_float_compare_unit
